// [hub_rst_pkg.sv]
package hub_rst_pkg;
  // link power states, one-hot
  typedef enum logic [2:0] {
    LINK_ON      = 3'b001,
    LINK_SLEEP   = 3'b010,
    LINK_SUSPEND = 3'b100
  } link_state_t;

  localparam int CLK_MHZ = 125;
  localparam int POR_HOLD_US = 1000;
  localparam int SLEEP_ENTRY_US = 10;
  localparam int SLEEP_EXIT_US = 50;
  localparam int SUSP_ENTRY_US = 3000;
  localparam int SUSP_EXIT_US = 2000;
  // longest times round down, less one so the move lands strictly under the bound
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_US * CLK_MHZ - 1;
  localparam int SLEEP_EXIT_CYC = SLEEP_EXIT_US * CLK_MHZ - 1;
  localparam int SUSP_ENTRY_CYC = SUSP_ENTRY_US * CLK_MHZ;
  localparam int SUSP_EXIT_CYC = SUSP_EXIT_US * CLK_MHZ;
  localparam int POR_HOLD_CYC = POR_HOLD_US * CLK_MHZ;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [7:0] CONFIG_NONE = 8'h00;
endpackage

// [hub_reset_and_link_power.sv]
`timescale 1ns/1ps
// Function
// - the link is always in exactly one of on, sleep or suspend, with on the working state.
// - entering sleep finishes in under 10 us and leaving sleep finishes in under 50 us.
// - entering suspend takes about 3 ms and resuming to on takes about 2 ms from resume start.
// - three reset sources are recognised: power-on, external chip reset and upstream bus reset.
// - a power-on timer holds the internal reset for a fixed interval before releasing it.
// - while chip reset is held the block sits in a low-current standby state.
// - chip reset disables the transceivers and floats every differential pair.
// - chip reset aborts all transactions at once and keeps no earlier state.
// - chip reset returns every internal register except the power-on timer to its default.
// - chip reset stops oscillator and PLL, which restart only after release.
// - a bus reset sets the device address to 0 and the configuration to unconfigured.
// - a bus reset while suspended moves the link to on, then normal post-reset behaviour follows.
// - a bus reset is never passed to downstream ports.
module hub_reset_and_link_power #(
  parameter int POR_CYCLES = hub_rst_pkg::POR_HOLD_CYC,
  parameter int SUSP_ENTRY_CYCLES = hub_rst_pkg::SUSP_ENTRY_CYC,
  parameter int SUSP_EXIT_CYCLES = hub_rst_pkg::SUSP_EXIT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chipRst_n,
  input wire logic busReset,
  input wire logic sleepReq,
  input wire logic suspendReq,
  input wire logic resumeReq,
  input wire logic setAddrValid,
  input wire logic [6:0] setAddr,
  input wire logic setConfigValid,
  input wire logic [7:0] setConfig,
  output logic chipRstOut,
  output logic standby,
  output logic phyEnable,
  output logic diffPairOe_n,
  output logic oscRun,
  output logic pllRun,
  output logic txnAbort,
  output logic [2:0] linkState,
  output logic linkBusy,
  output logic [6:0] devAddr,
  output logic [7:0] devConfig,
  output logic downstreamRst
);
  localparam int CW = 24;

  // every counter is CW bits wide, so each count has to fit below 2**CW
  if (POR_CYCLES < 1 || POR_CYCLES >= 2 ** CW || SUSP_ENTRY_CYCLES < 1 ||
      SUSP_ENTRY_CYCLES >= 2 ** CW || SUSP_EXIT_CYCLES < 1 ||
      SUSP_EXIT_CYCLES >= 2 ** CW) begin : g_bad_cycles
    $error("cycle counts must lie between one and the counter range");
  end
  logic [CW-1:0] porCnt_reg;
  logic porDone_reg;
  logic chipRst;
  hub_rst_pkg::link_state_t state_reg, state_next;
  logic [CW-1:0] moveCnt_reg;
  logic [CW-1:0] moveTarget;
  logic moving_reg;
  hub_rst_pkg::link_state_t dest_reg;
  logic [6:0] addr_reg;
  logic [7:0] cfg_reg;
  logic [CW-1:0] busyAge_reg;

  // power-on timer; sys_rst stands for power being applied or reapplied
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      porCnt_reg <= '0;
      porDone_reg <= 1'b0;
    end else if (!porDone_reg) begin
      porCnt_reg <= porCnt_reg + 1'b1;
      porDone_reg <= (porCnt_reg == CW'(POR_CYCLES - 1));
    end
  end

  // one chip reset from power-on and the pin; bus reset stays out of it
  assign chipRst = sys_rst | !porDone_reg | !chipRst_n;
  assign chipRstOut = chipRst;
  assign standby = !chipRst_n;
  assign phyEnable = !chipRst;
  assign diffPairOe_n = chipRst;
  assign oscRun = chipRst_n;
  assign pllRun = chipRst_n;
  assign txnAbort = chipRst;
  assign downstreamRst = 1'b0;
  assign linkState = state_reg;
  assign linkBusy = moving_reg;

  // latency of the pending move; suspend exit counts from resume start
  assign moveTarget = (dest_reg == hub_rst_pkg::LINK_SLEEP) ? CW'(hub_rst_pkg::SLEEP_ENTRY_CYC) :
                      (dest_reg == hub_rst_pkg::LINK_SUSPEND) ? CW'(SUSP_ENTRY_CYCLES) :
                      (state_reg == hub_rst_pkg::LINK_SLEEP) ? CW'(hub_rst_pkg::SLEEP_EXIT_CYC) :
                      CW'(SUSP_EXIT_CYCLES);

  // next settled state once the move count is reached
  always_comb begin
    state_next = state_reg;
    if (moving_reg && moveCnt_reg == moveTarget - 1'b1) begin
      state_next = dest_reg;
    end
  end

  // link power state machine; bus reset forces on, which beats any move
  always_ff @(posedge clk or posedge chipRst) begin
    if (chipRst) begin
      state_reg <= hub_rst_pkg::LINK_ON;
      dest_reg <= hub_rst_pkg::LINK_ON;
      moving_reg <= 1'b0;
      moveCnt_reg <= '0;
    end else if (busReset) begin
      state_reg <= hub_rst_pkg::LINK_ON;
      dest_reg <= hub_rst_pkg::LINK_ON;
      moving_reg <= 1'b0;
      moveCnt_reg <= '0;
    end else if (moving_reg) begin
      state_reg <= state_next;
      moveCnt_reg <= moveCnt_reg + 1'b1;
      moving_reg <= (state_next != dest_reg);
    end else begin
      moveCnt_reg <= '0;
      unique case (state_reg)
        hub_rst_pkg::LINK_ON: begin
          if (suspendReq) begin
            dest_reg <= hub_rst_pkg::LINK_SUSPEND;
            moving_reg <= 1'b1;
          end else if (sleepReq) begin
            dest_reg <= hub_rst_pkg::LINK_SLEEP;
            moving_reg <= 1'b1;
          end
        end
        hub_rst_pkg::LINK_SLEEP, hub_rst_pkg::LINK_SUSPEND: begin
          if (resumeReq) begin
            dest_reg <= hub_rst_pkg::LINK_ON;
            moving_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  // address and configuration; bus reset clears these as well as the link state machine
  always_ff @(posedge clk or posedge chipRst) begin
    if (chipRst) begin
      addr_reg <= hub_rst_pkg::ADDR_RESET;
      cfg_reg <= hub_rst_pkg::CONFIG_NONE;
    end else if (busReset) begin
      addr_reg <= hub_rst_pkg::ADDR_RESET;
      cfg_reg <= hub_rst_pkg::CONFIG_NONE;
    end else begin
      if (setAddrValid) addr_reg <= setAddr;
      if (setConfigValid) cfg_reg <= setConfig;
    end
  end
  assign devAddr = addr_reg;
  assign devConfig = cfg_reg;

  // age of the pending move; lets the latency checks use a counter, not a long delay range
  always_ff @(posedge clk or posedge chipRst) begin
    if (chipRst) begin
      busyAge_reg <= '0;
    end else if (moving_reg) begin
      busyAge_reg <= busyAge_reg + 1'b1;
    end else begin
      busyAge_reg <= '0;
    end
  end

  // checks
  property p_bus_clear;
    @(posedge clk) disable iff (chipRst) busReset |=> (devAddr == 7'h00 && devConfig == 8'h00);
  endproperty
  a_bus_clear: assert property (p_bus_clear) else $error("bus reset left address or config");
  property p_bus_wake;
    @(posedge clk) disable iff (chipRst) busReset |=> (linkState == 3'b001 && !linkBusy);
  endproperty
  a_bus_wake: assert property (p_bus_wake) else $error("bus reset did not wake link");
  property p_no_fwd;
    @(posedge clk) !downstreamRst;
  endproperty
  a_no_fwd: assert property (p_no_fwd) else $error("reset passed downstream");
  property p_phy_off;
    @(posedge clk) !chipRst_n |-> (!phyEnable && diffPairOe_n && txnAbort && !oscRun && !pllRun);
  endproperty
  a_phy_off: assert property (p_phy_off) else $error("pin reset left phy or clocks on");
  property p_onehot;
    @(posedge clk) disable iff (chipRst) $onehot(linkState);
  endproperty
  a_onehot: assert property (p_onehot) else $error("link state not one-hot");
  property p_sleep_entry;
    @(posedge clk) disable iff (chipRst)
      (moving_reg && dest_reg == hub_rst_pkg::LINK_SLEEP) |->
      busyAge_reg < CW'(hub_rst_pkg::SLEEP_ENTRY_CYC);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry too slow");
  property p_sleep_exit;
    @(posedge clk) disable iff (chipRst)
      (moving_reg && dest_reg == hub_rst_pkg::LINK_ON && state_reg == hub_rst_pkg::LINK_SLEEP) |->
      busyAge_reg < CW'(hub_rst_pkg::SLEEP_EXIT_CYC);
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit too slow");
  property p_susp_entry;
    @(posedge clk) disable iff (chipRst)
      (moving_reg && dest_reg == hub_rst_pkg::LINK_SUSPEND) |->
      busyAge_reg < CW'(SUSP_ENTRY_CYCLES);
  endproperty
  a_susp_entry: assert property (p_susp_entry) else $error("suspend entry too slow");
  property p_susp_exit;
    @(posedge clk) disable iff (chipRst)
      (moving_reg && dest_reg == hub_rst_pkg::LINK_ON && state_reg == hub_rst_pkg::LINK_SUSPEND) |->
      busyAge_reg < CW'(SUSP_EXIT_CYCLES);
  endproperty
  a_susp_exit: assert property (p_susp_exit) else $error("suspend exit too slow");
  property p_standby;
    @(posedge clk) standby == !chipRst_n;
  endproperty
  a_standby: assert property (p_standby) else $error("standby does not follow pin");
  property p_por_hold;
    @(posedge clk) disable iff (sys_rst) $rose(porDone_reg) |-> $past(porCnt_reg) == CW'(POR_CYCLES - 1);
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("power-on hold length wrong");
  c_sleep: cover property (@(posedge clk) linkState == 3'b010);
  c_suspend: cover property (@(posedge clk) linkState == 3'b100);
  c_bus_wake: cover property (@(posedge clk) linkState == 3'b100 && busReset);
  c_pin_rst: cover property (@(posedge clk) $fell(chipRst_n));
  c_resume: cover property (@(posedge clk) $fell(linkBusy) && linkState == 3'b001);
endmodule // hub_reset_and_link_power

// [upstream_host_model.sv]
`timescale 1ns/1ps
// upstream host: drives bus reset and link power requests as levels
module upstream_host_model (
  input wire logic clk,
  input wire logic linkBusy,
  output logic busReset,
  output logic sleepReq,
  output logic suspendReq,
  output logic resumeReq
);
  int timeouts;
  initial begin
    busReset = 1'b0;
    {sleepReq, suspendReq, resumeReq} = 3'b000;
    timeouts = 0;
  end
  // waits for a settled link so the request is not silently dropped
  task automatic lpm(input int k);
    int w;
    w = 0;
    while (linkBusy && w < 10000) begin
      @(posedge clk);
      #1;
      w++;
    end
    if (w == 10000) timeouts++;
    {sleepReq, suspendReq, resumeReq} = {k == 0, k == 1, k == 2};
    @(posedge clk);
    #1;
    {sleepReq, suspendReq, resumeReq} = 3'b000;
  endtask
  // bus reset held as a level for len edges
  task automatic bus_reset(input int len);
    busReset = 1'b1;
    repeat (len) @(posedge clk);
    #1 busReset = 1'b0;
  endtask
endmodule // upstream_host_model

// [hub_reset_and_link_power_tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module hub_reset_and_link_power_tb;
  logic clk, sys_rst, chipRst_n, setAddrValid, setConfigValid;
  logic [6:0] setAddr, devAddr, mAddr;
  logic [7:0] setConfig, devConfig, mCfg;
  logic busReset, sleepReq, suspendReq, resumeReq, chipRstOut, standby, phyEnable;
  logic diffPairOe_n, oscRun, pllRun, txnAbort, linkBusy, downstreamRst;
  logic [2:0] linkState;
  logic [31:0] seed = 32'hc4be;
  int fail_count = 0, samples_checked = 0, n;
  always #4 clk = ~clk;
  hub_reset_and_link_power #(.POR_CYCLES(16), .SUSP_ENTRY_CYCLES(40), .SUSP_EXIT_CYCLES(30))
    u_hub_reset_and_link_power (.*);
  upstream_host_model u_host (.*);
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // a hung design must still reach the verdict
  initial begin
    #400000 fail_count++;
    test_done();
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // random address and configuration, also kept in the model
  task automatic setcfg();
    seed = nx(seed);
    {setAddrValid, setConfigValid, setAddr, setConfig} = {2'b11, seed[6:0], seed[15:8]};
    {mAddr, mCfg} = {seed[6:0], seed[15:8]};
    @(posedge clk);
    #1 {setAddrValid, setConfigValid} = 2'b00;
    `CHK("cfg", {mAddr, mCfg}, {devAddr, devConfig})
  endtask
  // counts edges from the taking edge to the settled state
  task automatic move(input int k, input int lat, input logic [2:0] st);
    u_host.lpm(k);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (linkBusy && n < 10000);
    if (n == 10000) fail_count++;
    `CHK("latency", lat, n)
    `CHK("state", st, linkState)
    $display("move %0d done", k);
  endtask
  initial begin
    {clk, sys_rst, chipRst_n, setAddrValid, setConfigValid} = 5'b01100;
    {setAddr, setConfig} = 15'h0000;
    repeat (12) @(posedge clk);
    #1 sys_rst = 0;
    n = 0;
    while (chipRstOut !== 1'b0 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK("por hold", 16, n)
    `CHK("idle", {3'(hub_rst_pkg::LINK_ON), 8'h2c}, {linkState, chipRstOut, standby,
      phyEnable, diffPairOe_n, oscRun, pllRun, txnAbort, linkBusy})
    setcfg();
    move(0, hub_rst_pkg::SLEEP_ENTRY_CYC, hub_rst_pkg::LINK_SLEEP);
    move(2, hub_rst_pkg::SLEEP_EXIT_CYC, hub_rst_pkg::LINK_ON);
    // bus reset aborts a suspend move eleven edges into its forty
    u_host.lpm(1);
    repeat (10) @(posedge clk);
    #1 u_host.bus_reset(4);
    `CHK("abort", {3'(hub_rst_pkg::LINK_ON), 1'b0}, {linkState, linkBusy})
    move(1, 40, hub_rst_pkg::LINK_SUSPEND);
    move(2, 30, hub_rst_pkg::LINK_ON);
    setcfg();
    move(1, 40, hub_rst_pkg::LINK_SUSPEND);
    u_host.bus_reset(3);
    {mAddr, mCfg} = 15'h0000;
    `CHK("bus rst", {3'(hub_rst_pkg::LINK_ON), mAddr, mCfg, 1'b0},
      {linkState, devAddr, devConfig, downstreamRst})
    $display("bus reset done");
    // chip reset in mid move; supplies and clock are steady throughout
    setcfg();
    u_host.lpm(0);
    repeat (5) @(posedge clk);
    #1 chipRst_n = 0;
    #1 `CHK("rst pins", 8'hd2, {chipRstOut, standby, phyEnable, diffPairOe_n, oscRun,
      pllRun, txnAbort, linkBusy})
    repeat (625) @(posedge clk);
    #1 `CHK("rst regs", {3'(hub_rst_pkg::LINK_ON), 15'h0000}, {linkState, devAddr,
      devConfig})
    chipRst_n = 1;
    @(posedge clk);
    #1 `CHK("released", 8'h2c, {chipRstOut, standby, phyEnable, diffPairOe_n, oscRun,
      pllRun, txnAbort, linkBusy})
    $display("chip reset done");
    // the link must work again straight after the pin is released
    move(0, hub_rst_pkg::SLEEP_ENTRY_CYC, hub_rst_pkg::LINK_SLEEP);
    `CHK("host waits", 0, u_host.timeouts)
    test_done();
  end
endmodule // hub_reset_and_link_power_tb
